/* File: rtl/wcb_regs.svh */
// Behaviour
// - PCI-style address, multiplied data rate, flow control
// - Data dwords follow start address, plus four each
// - Eight dwords per port clock at 8x
// - Address phase always goes at 1x
// - 64 bytes at 8x: one plus two clocks
// - Buffers drain lowest dword first, ascending
// - Uncacheable read or interrupt flushes open buffer
// - New cache line closes buffer; one buffer open
// - Store fence flushes partial buffer at once
// - Full buffer is sent immediately
// - Attribute entries: 00h uncacheable, 07h uncacheable-minus
// - Range register matches base/mask on 4-Kbyte pages
// - Aligned full line leaves as one burst
`ifndef WCB_REGS_SVH
`define WCB_REGS_SVH

// ==========================================================================
// Register indices; the byte address is four times the index.
`define IDX_ATTR_LO 12'h277
`define IDX_ATTR_HI 12'h278
`define IDX_RANGE_BASE 12'h280
`define IDX_RANGE_MASK 12'h281
`define IDX_CTRL 12'h282
`define IDX_STATUS 12'h283

// ==========================================================================
// Reset values and fields.
`define ATTR_RESET 64'h0000_0000_0000_0000
`define RANGE_RESET 32'h0000_0000
`define CTRL_RESET 32'h0000_0002
`define RANGE_VALID_BIT 11
`define PAGE_LSB 12
`define LINE_LSB 6
`define TYPE_UNCACHED 8'h00
`define TYPE_COMBINE 8'h01
`define TYPE_UCM 8'h07

// ==========================================================================
// Sizes and timing.
`define LINE_DWORDS 16
`define LANES_MAX 8
`define FIFO_WIDTH 38
`define FIFO_DEPTH 16
`define CLK_PERIOD_PS 8000
`define PORT_CLK_PS 15152
`define PORT_CLK_CYC ((`PORT_CLK_PS / `CLK_PERIOD_PS) < 1 ? 1 : \
   (`PORT_CLK_PS / `CLK_PERIOD_PS))

`endif

/* File: rtl/wcb_pkg.sv */
package wcb_pkg;
   typedef enum logic [2:0] {
      W_COLLECT = 3'b001,
      W_DRAIN_ADDR = 3'b010,
      W_DRAIN_DATA = 3'b100
   } wr_state_e;

   typedef enum logic [2:0] {
      L_IDLE = 3'b001,
      L_GATHER = 3'b010,
      L_SEND = 3'b100
   } link_state_e;

   typedef enum logic [1:0] {
      RATE_2X = 2'h0,
      RATE_4X = 2'h1,
      RATE_8X = 2'h2
   } rate_e;
endpackage : wcb_pkg

/* File: rtl/wcb_fifo.sv */
`timescale 1ns/10ps
module wcb_fifo #(
   parameter int WIDTH = 38,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Fill side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // Occupancy, output register included.
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic ov_q, ov_d;
   logic [WIDTH-1:0] od_q, od_d;
   logic push, load;

   // ========================================================================
   // Read data leave through a register so the array stays plain storage.
   always_comb begin
      push = in_valid && in_ready;
      load = (cnt_q != '0) && (!ov_q || out_ready);
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = load ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q + (push ? 1'b1 : 1'b0) - (load ? 1'b1 : 1'b0);
      od_d = load ? mem_q[rd_q] : od_q;
      ov_d = load ? 1'b1 : (out_ready ? 1'b0 : ov_q);
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
      if (srst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         ov_q <= 1'b0;
         od_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         ov_q <= ov_d;
         od_q <= od_d;
      end
   end

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = ov_q;
   assign out_data = od_q;
   assign level = cnt_q + (ov_q ? 1'b1 : 1'b0);
endmodule : wcb_fifo

/* File: rtl/wc_fast_write_burst_bridge.sv */
// Register access over APB was decided locally.
`timescale 1ns/10ps
`include "wcb_regs.svh"
module wc_fast_write_burst_bridge (
   // Clock and reset.
   input wire logic CLOCK,
   input wire logic SRST,
   // APB register port.
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Processor store path.
   input wire logic ST_VALID,
   output logic ST_READY,
   input wire logic [31:0] ST_ADDR,
   input wire logic [31:0] ST_DATA,
   input wire logic [2:0] ST_ATTR_SEL,
   input wire logic ST_FENCE,
   input wire logic ST_UNC_READ,
   input wire logic ST_IRQ,
   // Fast-write port toward the accelerator.
   output logic FW_FRAME,
   output logic FW_STROBE,
   output logic FW_ADDR_PHASE,
   output logic FW_LAST,
   output logic [255:0] FW_DATA,
   output logic [31:0] FW_BE,
   output logic [3:0] FW_LANES,
   input wire logic FW_READY
);
   import wcb_pkg::*;

   // ========================================================================
   // Register file.
   logic [63:0] attr_q, attr_d;
   logic [31:0] mbase_q, mbase_d, mmask_q, mmask_d, ctrl_q, ctrl_d;
   logic [31:0] rdata_q, rdata_d;
   logic ready_q, ready_d, err_q, err_d;
   logic [15:0] bursts_q, bursts_d;
   logic [9:0] idx;
   logic hit, wr_go;
   logic [31:0] status;
   logic [4:0] fifo_level;

   always_comb begin
      idx = PADDR[11:2];
      attr_d = attr_q;
      mbase_d = mbase_q;
      mmask_d = mmask_q;
      ctrl_d = ctrl_q;
      rdata_d = rdata_q;
      err_d = 1'b0;
      hit = 1'b1;
      // The answer is ready in the first cycle of the access phase.
      ready_d = PSEL && !PENABLE && !ready_q;
      wr_go = PSEL && PENABLE && ready_q && PWRITE && !err_q;
      if (idx == `IDX_ATTR_LO) begin
         rdata_d = attr_q[31:0];
      end else if (idx == `IDX_ATTR_HI) begin
         rdata_d = attr_q[63:32];
      end else if (idx == `IDX_RANGE_BASE) begin
         rdata_d = mbase_q;
      end else if (idx == `IDX_RANGE_MASK) begin
         rdata_d = mmask_q;
      end else if (idx == `IDX_CTRL) begin
         rdata_d = ctrl_q;
      end else if (idx == `IDX_STATUS) begin
         rdata_d = status;
      end else begin
         hit = 1'b0;
         rdata_d = 32'h0000_0000;
      end
      if (PSEL && !PENABLE) begin
         err_d = !hit;
      end else if (!ready_d) begin
         rdata_d = rdata_q;
      end
      if (wr_go) begin
         if (idx == `IDX_ATTR_LO) begin
            attr_d[31:0] = PWDATA;
         end else if (idx == `IDX_ATTR_HI) begin
            attr_d[63:32] = PWDATA;
         end else if (idx == `IDX_RANGE_BASE) begin
            mbase_d = PWDATA;
         end else if (idx == `IDX_RANGE_MASK) begin
            mmask_d = PWDATA;
         end else if (idx == `IDX_CTRL) begin
            ctrl_d = {30'h0000_0000, PWDATA[1:0]};
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         attr_q <= `ATTR_RESET;
         mbase_q <= `RANGE_RESET;
         mmask_q <= `RANGE_RESET;
         ctrl_q <= `CTRL_RESET;
         rdata_q <= 32'h0000_0000;
         ready_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         attr_q <= attr_d;
         mbase_q <= mbase_d;
         mmask_q <= mmask_d;
         ctrl_q <= ctrl_d;
         rdata_q <= rdata_d;
         ready_q <= ready_d;
         err_q <= err_d;
      end
   end

   assign PRDATA = rdata_q;
   assign PREADY = ready_q;
   // The error flag lives only in the access cycle, so it leaves directly.
   assign PSLVERR = err_q;

   // ========================================================================
   // Memory type of the incoming store.
   logic [7:0] attr_type;
   logic range_hit, combine;

   always_comb begin
      attr_type = attr_q[{ST_ATTR_SEL, 3'h0} +: 8];
      // Only page-number bits take part in the match.
      range_hit = mmask_q[`RANGE_VALID_BIT] &&
         ((ST_ADDR[31:`PAGE_LSB] & mmask_q[31:`PAGE_LSB]) ==
          (mbase_q[31:`PAGE_LSB] & mmask_q[31:`PAGE_LSB]));
      // Uncacheable beats the range register; uncacheable-minus yields.
      combine = (attr_type == `TYPE_COMBINE) ||
         (range_hit && attr_type == `TYPE_UCM);
   end

   // ========================================================================
   // Write-combining buffer; one line is open at a time.
   wr_state_e ws_q, ws_d;
   logic [31:0] buf_q [`LINE_DWORDS];
   logic [31:0] buf_d [`LINE_DWORDS];
   logic [15:0] mask_q, mask_d;
   logic [25:0] line_q, line_d;
   logic [3:0] di_q, di_d, lo, hi;
   logic pend_q, pend_d, solo_q, solo_d, evt_q, evt_d, st_rdy_q, st_rdy_d;
   logic [31:0] paddr_q, paddr_d, pdata_q, pdata_d;
   logic fin_valid, fin_ready, accept, found;
   logic [37:0] fin_data;

   always_comb begin
      lo = 4'h0;
      hi = 4'h0;
      found = 1'b0;
      for (int i = 0; i < `LINE_DWORDS; i++) begin
         if (mask_q[i]) begin
            if (!found) begin
               lo = 4'(i);
            end
            found = 1'b1;
            hi = 4'(i);
         end
      end
   end

   always_comb begin
      ws_d = ws_q;
      buf_d = buf_q;
      mask_d = mask_q;
      line_d = line_q;
      di_d = di_q;
      pend_d = pend_q;
      solo_d = solo_q;
      paddr_d = paddr_q;
      pdata_d = pdata_q;
      fin_valid = 1'b0;
      fin_data = '0;
      evt_d = evt_q || ST_FENCE || ST_UNC_READ || ST_IRQ;
      accept = ST_VALID && st_rdy_q;
      case (ws_q)
         W_COLLECT: begin
            if (accept) begin
               if (mask_q != 16'h0000 && (!combine ||
                   ST_ADDR[31:`LINE_LSB] != line_q)) begin
                  // Another line or an uncached store closes the buffer.
                  pend_d = 1'b1;
                  solo_d = !combine;
                  paddr_d = ST_ADDR;
                  pdata_d = ST_DATA;
                  ws_d = W_DRAIN_ADDR;
               end else begin
                  buf_d[ST_ADDR[5:2]] = ST_DATA;
                  mask_d[ST_ADDR[5:2]] = 1'b1;
                  line_d = ST_ADDR[31:`LINE_LSB];
                  if (!combine || mask_d == 16'hFFFF) begin
                     ws_d = W_DRAIN_ADDR;
                  end
               end
            end
            if (evt_d) begin
               evt_d = 1'b0;
               if (mask_d != 16'h0000) begin
                  ws_d = W_DRAIN_ADDR;
               end
            end
         end
         W_DRAIN_ADDR: begin
            // The burst starts at the lowest written dword.
            fin_valid = 1'b1;
            fin_data = {1'b1, 1'b0, 4'hF, line_q, lo, 2'b00};
            if (fin_ready) begin
               di_d = lo;
               ws_d = W_DRAIN_DATA;
            end
         end
         W_DRAIN_DATA: begin
            fin_valid = 1'b1;
            fin_data = {1'b0, di_q == hi, {4{mask_q[di_q]}},
               buf_q[di_q]};
            if (fin_ready) begin
               di_d = di_q + 4'h1;
               if (di_q == hi) begin
                  mask_d = 16'h0000;
                  ws_d = W_COLLECT;
                  if (pend_q) begin
                     pend_d = 1'b0;
                     buf_d[paddr_q[5:2]] = pdata_q;
                     mask_d[paddr_q[5:2]] = 1'b1;
                     line_d = paddr_q[31:`LINE_LSB];
                     ws_d = solo_q ? W_DRAIN_ADDR : W_COLLECT;
                  end
               end
            end
         end
         default: begin
            ws_d = W_COLLECT;
         end
      endcase
      st_rdy_d = (ws_d == W_COLLECT) && !pend_d;
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         ws_q <= W_COLLECT;
         mask_q <= 16'h0000;
         line_q <= '0;
         di_q <= 4'h0;
         pend_q <= 1'b0;
         solo_q <= 1'b0;
         evt_q <= 1'b0;
         st_rdy_q <= 1'b0;
         paddr_q <= 32'h0000_0000;
         pdata_q <= 32'h0000_0000;
         for (int i = 0; i < `LINE_DWORDS; i++) begin
            buf_q[i] <= 32'h0000_0000;
         end
      end else begin
         ws_q <= ws_d;
         mask_q <= mask_d;
         line_q <= line_d;
         di_q <= di_d;
         pend_q <= pend_d;
         solo_q <= solo_d;
         evt_q <= evt_d;
         st_rdy_q <= st_rdy_d;
         paddr_q <= paddr_d;
         pdata_q <= pdata_d;
         buf_q <= buf_d;
      end
   end

   assign ST_READY = st_rdy_q;

   // ========================================================================
   // Burst queue between the buffer and the port.
   logic fout_valid, fout_ready;
   logic [37:0] fout_data;

   wcb_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) u_fifo (
      .clk(CLOCK),
      .srst(SRST),
      .in_valid(fin_valid),
      .in_ready(fin_ready),
      .in_data(fin_data),
      .out_valid(fout_valid),
      .out_ready(fout_ready),
      .out_data(fout_data),
      .level(fifo_level)
   );

   // ========================================================================
   // Port side: one strobe is one port clock.
   link_state_e ls_q, ls_d;
   logic [255:0] lane_q, lane_d, fwd_q, fwd_d;
   logic [31:0] lbe_q, lbe_d, fbe_q, fbe_d;
   logic [3:0] cnt_q, cnt_d, rate, fln_q, fln_d;
   logic last_q, last_d, frame_q, frame_d, stb_q, stb_d;
   logic aph_q, aph_d, flast_q, flast_d;
   logic [2:0] pace_q, pace_d;

   always_comb begin
      case (rate_e'(ctrl_q[1:0]))
         RATE_2X: rate = 4'h2;
         RATE_4X: rate = 4'h4;
         default: rate = 4'h8;
      endcase
      ls_d = ls_q;
      lane_d = lane_q;
      lbe_d = lbe_q;
      cnt_d = cnt_q;
      last_d = last_q;
      frame_d = frame_q;
      fwd_d = fwd_q;
      fbe_d = fbe_q;
      fln_d = fln_q;
      stb_d = 1'b0;
      aph_d = 1'b0;
      flast_d = 1'b0;
      fout_ready = 1'b0;
      pace_d = (pace_q != 3'h0) ? pace_q - 3'h1 : 3'h0;
      case (ls_q)
         L_IDLE: begin
            fout_ready = pace_q == 3'h0;
            if (fout_valid && pace_q == 3'h0) begin
               if (fout_data[37]) begin
                  // Address goes alone on lane 0 at single rate.
                  stb_d = 1'b1;
                  aph_d = 1'b1;
                  frame_d = 1'b1;
                  fwd_d = {224'h0, fout_data[31:0]};
                  fbe_d = 32'h0000_000F;
                  fln_d = 4'h1;
                  pace_d = 3'(`PORT_CLK_CYC - 1);
                  cnt_d = 4'h0;
                  lane_d = '0;
                  lbe_d = 32'h0000_0000;
                  ls_d = L_GATHER;
               end
            end else if (pace_q == 3'h0) begin
               frame_d = 1'b0;
            end
         end
         L_GATHER: begin
            fout_ready = 1'b1;
            if (fout_valid) begin
               lane_d[cnt_q[2:0]*32 +: 32] = fout_data[31:0];
               lbe_d[cnt_q[2:0]*4 +: 4] = fout_data[35:32];
               cnt_d = cnt_q + 4'h1;
               last_d = fout_data[36];
               if (fout_data[36] || cnt_d == rate) begin
                  ls_d = L_SEND;
               end
            end
         end
         L_SEND: begin
            // Target back-pressure holds the block between data clocks.
            if (FW_READY && pace_q == 3'h0) begin
               stb_d = 1'b1;
               flast_d = last_q;
               fwd_d = lane_q;
               fbe_d = lbe_q;
               fln_d = cnt_q;
               pace_d = 3'(`PORT_CLK_CYC - 1);
               cnt_d = 4'h0;
               lane_d = '0;
               lbe_d = 32'h0000_0000;
               ls_d = last_q ? L_IDLE : L_GATHER;
            end
         end
         default: begin
            ls_d = L_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         ls_q <= L_IDLE;
         lane_q <= '0;
         lbe_q <= 32'h0000_0000;
         cnt_q <= 4'h0;
         last_q <= 1'b0;
         frame_q <= 1'b0;
         stb_q <= 1'b0;
         aph_q <= 1'b0;
         flast_q <= 1'b0;
         fwd_q <= '0;
         fbe_q <= 32'h0000_0000;
         fln_q <= 4'h0;
         pace_q <= 3'h0;
         bursts_q <= 16'h0000;
      end else begin
         ls_q <= ls_d;
         lane_q <= lane_d;
         lbe_q <= lbe_d;
         cnt_q <= cnt_d;
         last_q <= last_d;
         frame_q <= frame_d;
         stb_q <= stb_d;
         aph_q <= aph_d;
         flast_q <= flast_d;
         fwd_q <= fwd_d;
         fbe_q <= fbe_d;
         fln_q <= fln_d;
         pace_q <= pace_d;
         bursts_q <= bursts_d;
      end
   end

   assign bursts_d = bursts_q + (aph_d ? 16'h0001 : 16'h0000);
   assign status = {bursts_q, 3'h0, fifo_level, 1'b0, ls_q, 1'b0, ws_q};
   assign FW_FRAME = frame_q;
   assign FW_STROBE = stb_q;
   assign FW_ADDR_PHASE = aph_q;
   assign FW_LAST = flast_q;
   assign FW_DATA = fwd_q;
   assign FW_BE = fbe_q;
   assign FW_LANES = fln_q;
endmodule : wc_fast_write_burst_bridge

/* File: sim/wcb_chk.sv */
`timescale 1ns/10ps
// ==========================================================================
// Port-level checks of the fast-write bridge.
module wcb_chk (
   // Clock and reset.
   input wire logic CLOCK,
   input wire logic SRST,
   // Register port.
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // Fast-write port.
   input wire logic FW_FRAME,
   input wire logic FW_STROBE,
   input wire logic FW_ADDR_PHASE,
   input wire logic FW_LAST,
   input wire logic [255:0] FW_DATA,
   input wire logic [3:0] FW_LANES
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (SRST);

   a_addr_one_lane: assert property (FW_ADDR_PHASE |->
      FW_STROBE && FW_LANES == 4'h1) else $error("address strobe malformed");
   a_last_is_data: assert property (FW_LAST |->
      FW_STROBE && !FW_ADDR_PHASE) else $error("last flag off data strobe");
   a_lanes_in_range: assert property (FW_STROBE |->
      FW_LANES inside {[4'h1:4'h8]}) else $error("lane count out of range");
   a_strobe_framed: assert property (FW_STROBE |-> FW_FRAME)
      else $error("strobe outside frame");
   a_frame_opens: assert property ($rose(FW_FRAME) |-> FW_ADDR_PHASE)
      else $error("frame opened without address");
   a_data_holds: assert property (!FW_STROBE && !$past(SRST) |->
      $stable(FW_DATA)) else $error("data moved between strobes");
   a_ready_follows: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("no ready after setup");
   a_ready_single: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   a_err_with_ready: assert property (PSLVERR |-> PREADY && PSEL)
      else $error("error without ready");
endmodule : wcb_chk

bind wc_fast_write_burst_bridge wcb_chk chk_i (.CLOCK(CLOCK), .SRST(SRST),
   .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .FW_FRAME(FW_FRAME), .FW_STROBE(FW_STROBE), .FW_ADDR_PHASE(FW_ADDR_PHASE),
   .FW_LAST(FW_LAST), .FW_DATA(FW_DATA), .FW_LANES(FW_LANES));

/* File: sim/wcb_accel_model.sv */
`timescale 1ns/10ps
// ==========================================================================
// Accelerator command queue on the far side of the fast-write port.
module wcb_accel_model (
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Stall control from the bench.
   input wire logic slow,
   // Fast-write port.
   input wire logic strobe,
   input wire logic addr_phase,
   input wire logic last,
   input wire logic [255:0] data,
   input wire logic [31:0] be,
   input wire logic [3:0] lanes,
   output logic ready
);
   logic [1:0] cnt_q;
   logic [31:0] q_addr[$];
   logic [31:0] q_data[$];
   logic [3:0] q_be[$];
   logic [3:0] q_lanes[$];
   int n_last;

   // When slow, takes one block in four cycles to exercise flow control.
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_q <= 2'h0;
      end else begin
         cnt_q <= cnt_q + 2'h1;
      end
   end
   assign ready = !slow || cnt_q == 2'h3;

   // Words are kept in arrival order without limit, so any block fits.
   always @(posedge clk) begin
      if (srst) begin
         n_last = 0;
      end else if (strobe && addr_phase) begin
         q_addr.push_back(data[31:0]);
      end else if (strobe) begin
         q_lanes.push_back(lanes);
         for (int i = 0; i < 8; i++) begin
            if (i < lanes) begin
               q_data.push_back(data[32*i+:32]);
               q_be.push_back(be[4*i+:4]);
            end
         end
         if (last) begin
            n_last++;
         end
      end
   end
endmodule : wcb_accel_model

/* File: sim/wc_fast_write_burst_bridge_tb.sv */
`timescale 1ns/10ps
`include "wcb_regs.svh"
module wc_fast_write_burst_bridge_tb;
   logic clk, srst, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, st_addr, st_data, fw_be;
   logic st_valid, st_ready, fence, unc_rd, irq, slow;
   logic [2:0] st_sel;
   logic fw_frame, fw_strobe, fw_addr, fw_last, fw_ready;
   logic [255:0] fw_data;
   logic [3:0] fw_lanes;
   int n_errors, num_checks, n_bursts;

   wc_fast_write_burst_bridge uut (.CLOCK(clk), .SRST(srst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .ST_VALID(st_valid), .ST_READY(st_ready), .ST_ADDR(st_addr),
      .ST_DATA(st_data), .ST_ATTR_SEL(st_sel), .ST_FENCE(fence),
      .ST_UNC_READ(unc_rd), .ST_IRQ(irq), .FW_FRAME(fw_frame),
      .FW_STROBE(fw_strobe), .FW_ADDR_PHASE(fw_addr), .FW_LAST(fw_last),
      .FW_DATA(fw_data), .FW_BE(fw_be), .FW_LANES(fw_lanes),
      .FW_READY(fw_ready));
   wcb_accel_model pm (.clk(clk), .srst(srst), .slow(slow),
      .strobe(fw_strobe), .addr_phase(fw_addr), .last(fw_last),
      .data(fw_data), .be(fw_be), .lanes(fw_lanes), .ready(fw_ready));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ======================================================================
   // Shared tasks.
   task final_report;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report

   task timeout;
      n_errors++;
      $display("timeout at %0t", $time);
      final_report;
   endtask : timeout

   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
      int t;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx[9:0], 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      t = 0;
      // Ready and data are taken at the same rising edge as the slave.
      do begin
         @(posedge clk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      if (pready !== 1'b1) timeout;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rd_chk(input logic [11:0] idx, input logic [31:0] exp, input logic e);
      apb(1'b0, idx, 32'h0000_0000);
      chk(rd, exp);
      chk({31'h0, err}, {31'h0, e});
   endtask : rd_chk

   // Valid stays high between stores; ev() lowers it.
   task store(input logic [31:0] a, input logic [31:0] d, input logic [2:0] s);
      int t;
      st_valid <= 1'b1;
      st_addr <= a;
      st_data <= d;
      st_sel <= s;
      t = 0;
      do begin
         @(negedge clk);
         t++;
      end while (st_ready !== 1'b1 && t < 300);
      if (st_ready !== 1'b1) timeout;
      @(posedge clk);
   endtask : store

   // Event 0 fence, 1 uncacheable read, 2 interrupt, 3 none.
   task ev(input int k);
      st_valid <= 1'b0;
      fence <= (k == 0);
      unc_rd <= (k == 1);
      irq <= (k == 2);
      @(posedge clk);
      fence <= 1'b0;
      unc_rd <= 1'b0;
      irq <= 1'b0;
   endtask : ev

   task flush_wait(input int nb);
      int t;
      n_bursts += nb;
      t = 0;
      // Ends on a rising edge so the next stimulus is driven there.
      do begin
         @(posedge clk);
         t++;
      end while (pm.n_last < n_bursts && t < 3000);
      if (pm.n_last < n_bursts) timeout;
   endtask : flush_wait

   task burst_chk(input logic [31:0] a, input int n, input logic [31:0] d0,
         input logic [15:0] en, input int rate);
      int left;
      chk(pm.q_addr.pop_front(), a);
      for (int k = 0; k < n; k++) begin
         chk({28'h0, pm.q_be.pop_front()}, en[k] ? 32'hF : 32'h0);
         if (en[k]) begin
            chk(pm.q_data.pop_front(), d0 + k);
         end else begin
            void'(pm.q_data.pop_front());
         end
      end
      for (int s = 0; s * rate < n; s++) begin
         left = n - s * rate;
         chk({28'h0, pm.q_lanes.pop_front()}, left < rate ? left : rate);
      end
   endtask : burst_chk

   // ======================================================================
   // Main sequence.
   initial begin
      {psel, penable, pwrite, st_valid, fence, unc_rd, irq, slow} = 8'h00;
      {paddr, pwdata, st_addr, st_data, st_sel} = '0;
      srst = 1'b1;
      n_errors = 0;
      num_checks = 0;
      n_bursts = 0;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd_chk(`IDX_ATTR_LO, 32'h0000_0000, 1'b0);
      rd_chk(`IDX_ATTR_HI, 32'h0000_0000, 1'b0);
      rd_chk(`IDX_RANGE_BASE, `RANGE_RESET, 1'b0);
      rd_chk(`IDX_RANGE_MASK, `RANGE_RESET, 1'b0);
      rd_chk(`IDX_CTRL, `CTRL_RESET, 1'b0);
      // Idle status: both state machines in their first state, no bursts.
      rd_chk(`IDX_STATUS, 32'h0000_0011, 1'b0);
      rd_chk(12'h300, 32'h0000_0000, 1'b1);
      apb(1'b1, `IDX_ATTR_LO, 32'h0007_0100);
      rd_chk(`IDX_ATTR_LO, 32'h0007_0100, 1'b0);
      apb(1'b1, `IDX_RANGE_BASE, 32'h0000_2000);
      apb(1'b1, `IDX_RANGE_MASK, 32'hFFFF_F800);
      // Full line stored top down against a slow target.
      slow <= 1'b1;
      for (int k = 15; k >= 0; k--) store(32'h1000 + 4 * k, 32'hA000 + k, 3'h1);
      ev(3);
      flush_wait(1);
      burst_chk(32'h1000, 16, 32'hA000, 16'hFFFF, 8);
      slow <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         if (k != 2) store(32'h1040 + 4 * k, 32'hB000 + k, 3'h1);
      end
      ev(0);
      flush_wait(1);
      burst_chk(32'h1040, 4, 32'hB000, 16'h000B, 8);
      for (int e = 1; e < 3; e++) begin
         store(32'h1080 + 32'h40 * e, 32'hC000, 3'h1);
         ev(e);
         flush_wait(1);
         burst_chk(32'h1080 + 32'h40 * e, 1, 32'hC000, 16'h1, 8);
      end
      store(32'h1200, 32'hD000, 3'h1);
      store(32'h1240, 32'hD001, 3'h1);
      ev(0);
      flush_wait(2);
      burst_chk(32'h1200, 1, 32'hD000, 16'h1, 8);
      burst_chk(32'h1240, 1, 32'hD001, 16'h1, 8);
      // Uncacheable entry and range miss never combine; range hit does.
      store(32'h1280, 32'hE000, 3'h0);
      store(32'h1284, 32'hE001, 3'h0);
      store(32'h2000, 32'hF000, 3'h2);
      store(32'h2004, 32'hF001, 3'h2);
      store(32'h3000, 32'hF100, 3'h2);
      ev(3);
      flush_wait(4);
      burst_chk(32'h1280, 1, 32'hE000, 16'h1, 8);
      burst_chk(32'h1284, 1, 32'hE001, 16'h1, 8);
      burst_chk(32'h2000, 2, 32'hF000, 16'h3, 8);
      burst_chk(32'h3000, 1, 32'hF100, 16'h1, 8);
      for (int r = 0; r < 4; r++) begin
         apb(1'b1, `IDX_CTRL, r);
         @(posedge clk);
         for (int k = 0; k < 8; k++) store(32'h1400 + 4 * k, 32'h5000 + k, 3'h1);
         ev(0);
         flush_wait(1);
         burst_chk(32'h1400, 8, 32'h5000, 16'hFF, r == 3 ? 8 : 2 << r);
      end
      // Fourteen address phases were sent; everything is idle again.
      rd_chk(`IDX_STATUS, 32'h000E_0011, 1'b0);
      final_report;
   end
endmodule : wc_fast_write_burst_bridge_tb
